// file: include/aof_pkg.sv
/*
 holds the word width, codes, strobe timing and reset values for the output formatter.
 assumes a single converter clock drives every consumer of these constants.
*/
// Behaviour
// - each result leaves as a 16-bit two's complement word.
// - above positive full scale the word saturates to 7FFFh and the flag rises.
// - below negative full scale the word saturates to 8000h and the flag rises.
// - the flag stays high while the input remains out of range.
// - the flag rises only at the strobe falling edge for an overrange word.
// - the flag clears at a strobe falling edge once the code is back in range.
// - a fresh word is signalled by driving the strobe from high to low.
package aof_pkg;
  localparam int              DATA_W       = 16;
  localparam int              RAW_W        = 20;
  localparam logic [15:0]     CODE_POS_MAX = 16'h7FFF;
  localparam logic [15:0]     CODE_NEG_MAX = 16'h8000;
  localparam logic [15:0]     WORD_RST     = 16'h0000;
  localparam int              FIFO_DEPTH   = 8;
  localparam int              STROBE_HIGH_CYC = 1;
  localparam int              STROBE_PERIOD_CYC = 8;
endpackage : aof_pkg

// file: rtl/aof_top.sv
/*
 output formatter: saturates raw filter results to 16-bit two's complement words,
 flags overrange, buffers words in a fifo and presents them with a falling strobe.
 assumes the raw result source is on i_clk and is stalled by o_raw_ready.
*/
`timescale 1ns/1ps

module aof_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_sys_rst,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  logic             in_ready_reg;
  logic             push;
  logic             pop;

  // ready leaves from a flop; it falls on the edge that stores the last free word
  assign o_in_ready  = in_ready_reg;
  assign count_next  = count_reg + (AW+1)'(push) - (AW+1)'(pop);
  assign o_out_valid = (count_reg != '0);
  assign o_out_data  = mem_reg[rd_ptr_reg];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      in_ready_reg <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg    <= count_next;
      in_ready_reg <= (count_next != (AW+1)'(DEPTH));
    end
  end

  AST_READY_MATCHES_ROOM: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_in_ready == (count_reg != (AW+1)'(DEPTH)))
    else $error("fifo ready disagrees with fill level");
endmodule : aof_fifo

module aof_top (
  input  wire logic                 i_clk,
  input  wire logic                 i_sys_rst,
  input  wire logic                 i_raw_valid,
  input  wire logic signed [aof_pkg::RAW_W-1:0] i_raw_data,
  output logic                      o_raw_ready,
  output logic [aof_pkg::DATA_W-1:0] o_word,
  output logic                      o_range_exceeded_flag,
  output logic                      o_new_word_strobe_n
);
  import aof_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_HIGH, ST_LOW} aof_state_t;

  localparam logic signed [RAW_W-1:0] RAW_POS = RAW_W'(signed'(CODE_POS_MAX));
  localparam logic signed [RAW_W-1:0] RAW_NEG = {{(RAW_W-DATA_W){1'b1}}, CODE_NEG_MAX};

  aof_state_t        state_reg;
  logic [3:0]        cnt_reg;
  logic [DATA_W:0]   fmt_word;
  logic              fifo_valid;
  logic              fifo_pop;
  logic [DATA_W:0]   fifo_data;

  function automatic logic [DATA_W:0] aof_saturate(input logic signed [RAW_W-1:0] raw);
    if (raw > RAW_POS) begin
      aof_saturate = {1'b1, CODE_POS_MAX};
    end else if (raw < RAW_NEG) begin
      aof_saturate = {1'b1, CODE_NEG_MAX};
    end else begin
      aof_saturate = {1'b0, raw[DATA_W-1:0]};
    end
  endfunction : aof_saturate

  assign fmt_word = aof_saturate(i_raw_data);

  aof_fifo #(.WIDTH(DATA_W+1), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk       (i_clk),
    .i_sys_rst   (i_sys_rst),
    .i_in_valid  (i_raw_valid),
    .o_in_ready  (o_raw_ready),
    .i_in_data   (fmt_word),
    .o_out_valid (fifo_valid),
    .i_out_ready (fifo_pop),
    .o_out_data  (fifo_data)
  );

  // a new word may fall only after the strobe has stood high and the period elapsed
  assign fifo_pop = fifo_valid && (state_reg == ST_HIGH) && (cnt_reg == 4'(STROBE_HIGH_CYC - 1));

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= '0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          state_reg <= ST_HIGH;
          cnt_reg   <= '0;
        end
        ST_HIGH: begin
          if (fifo_pop) begin
            state_reg <= ST_LOW;
            cnt_reg   <= 4'(STROBE_HIGH_CYC);
          end else if (cnt_reg != 4'(STROBE_HIGH_CYC - 1)) begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        ST_LOW: begin
          if (cnt_reg == 4'(STROBE_PERIOD_CYC - 1)) begin
            state_reg <= ST_HIGH;
            cnt_reg   <= '0;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_new_word_strobe_n <= 1'b1;
    end else if (fifo_pop) begin
      o_new_word_strobe_n <= 1'b0;
    end else if (state_reg == ST_LOW && cnt_reg == 4'(STROBE_PERIOD_CYC - 1)) begin
      o_new_word_strobe_n <= 1'b1;
    end
  end

  // word and flag load in the one cycle the strobe falls
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_word                <= WORD_RST;
      o_range_exceeded_flag <= 1'b0;
    end else if (fifo_pop) begin
      o_word                <= fifo_data[DATA_W-1:0];
      o_range_exceeded_flag <= fifo_data[DATA_W];
    end
  end

  AST_FLAG_AT_FALL: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $changed(o_range_exceeded_flag) |-> $fell(o_new_word_strobe_n))
    else $error("flag moved without a strobe fall");

  AST_WORD_AT_FALL: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $changed(o_word) |-> $fell(o_new_word_strobe_n))
    else $error("word moved without a strobe fall");

  AST_POS_SAT: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_raw_valid && i_raw_data > RAW_POS) |-> (fmt_word == {1'b1, CODE_POS_MAX}))
    else $error("positive overrange not saturated");

  AST_NEG_SAT: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_raw_valid && i_raw_data < RAW_NEG) |-> (fmt_word == {1'b1, CODE_NEG_MAX}))
    else $error("negative overrange not saturated");

  AST_IN_RANGE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_raw_valid && i_raw_data <= RAW_POS && i_raw_data >= RAW_NEG)
      |-> (fmt_word == {1'b0, i_raw_data[DATA_W-1:0]}))
    else $error("in range word altered");

  AST_FLAG_TRACKS: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    fifo_pop |=> (o_range_exceeded_flag == $past(fifo_data[DATA_W])))
    else $error("flag does not follow the presented word");

  AST_FLAG_CLEARS: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (fifo_pop && !fifo_data[DATA_W]) |=> !o_range_exceeded_flag)
    else $error("flag not cleared for in range word");

  AST_STROBE_LOW: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $fell(o_new_word_strobe_n) |-> !o_new_word_strobe_n [*7] ##1 o_new_word_strobe_n)
    else $error("strobe low time wrong");

  AST_FALL_NEEDS_WORD: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $fell(o_new_word_strobe_n) |-> $past(fifo_valid))
    else $error("strobe fell with no word waiting");

  AST_POP_STROBE_HIGH: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    fifo_pop |-> o_new_word_strobe_n)
    else $error("word taken while strobe already low");

  AST_FLAG_HOLDS: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !fifo_pop |=> $stable(o_range_exceeded_flag))
    else $error("flag moved between words");

  // a raised flag can only sit beside a saturated code
  AST_FLAG_POS_CODE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (o_range_exceeded_flag && !o_word[DATA_W-1]) |-> (o_word == CODE_POS_MAX))
    else $error("flagged positive word not at full scale");

  AST_FLAG_NEG_CODE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (o_range_exceeded_flag && o_word[DATA_W-1]) |-> (o_word == CODE_NEG_MAX))
    else $error("flagged negative word not at full scale");

endmodule : aof_top

// file: test/aof_host_model.sv
/*
 host model: latches each presented word and flag at the strobe falling edge.
 assumes the strobe and word are settled by the falling clock edge.
*/
`timescale 1ns/1ps

module aof_host_model (
  input  wire logic        i_clk,
  input  wire logic        i_strobe_n,
  input  wire logic [15:0] i_word,
  input  wire logic        i_flag,
  output logic [15:0]      o_word,
  output logic             o_flag,
  output logic             o_tick
);
  logic last_reg = 1'b1;
  initial o_tick = 1'b0;
  always @(negedge i_clk) begin
    last_reg <= i_strobe_n;
    // tick stands one full clock so the bench can sample it at the rising edge
    o_tick   <= last_reg && !i_strobe_n;
    if (last_reg && !i_strobe_n) begin
      o_word <= i_word;
      o_flag <= i_flag;
    end
  end
endmodule : aof_host_model

// file: test/aof_top_test.sv
/*
 bench for the output formatter: random and boundary raw results against a queue model.
 assumes the fifo refuses only when full and words leave in order.
*/
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((e) !== (s)) begin error_cnt++; \
  $display("mismatch %s expected %h seen %h", n, e, s); end end

module aof_top_test;
  import aof_pkg::*;
  logic i_clk = 0, i_sys_rst = 1, i_raw_valid = 0, h_flag, h_tick;
  logic signed [19:0] i_raw_data = 0;
  logic o_raw_ready, o_range_exceeded_flag, o_new_word_strobe_n;
  logic [15:0] o_word, h_word;
  logic [16:0] q[$];
  int error_cnt = 0, checked = 0, cyc = 0, seed = 11, r;
  aof_top uut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_raw_valid(i_raw_valid),
    .i_raw_data(i_raw_data), .o_raw_ready(o_raw_ready), .o_word(o_word),
    .o_range_exceeded_flag(o_range_exceeded_flag), .o_new_word_strobe_n(o_new_word_strobe_n));
  aof_host_model host (.i_clk(i_clk), .i_strobe_n(o_new_word_strobe_n), .i_word(o_word),
    .i_flag(o_range_exceeded_flag), .o_word(h_word), .o_flag(h_flag), .o_tick(h_tick));
  initial forever #12.5 i_clk = ~i_clk;
  function automatic logic [16:0] sat(input logic signed [19:0] v);
    if (v > 20'sd32767) return {1'b1, CODE_POS_MAX};
    if (v < -20'sd32768) return {1'b1, CODE_NEG_MAX};
    return {1'b0, v[15:0]};
  endfunction : sat
  task results;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  // offered word held until the fifo takes it or 200 tries pass
  task put(input logic [19:0] v);
    int n;
    n = 0;
    do begin
      @(negedge i_clk);
      i_raw_valid = 1;
      i_raw_data = v;
      #1 n++;
      `CHK("ready", (q.size() - int'(h_tick)) < FIFO_DEPTH, o_raw_ready)
    end while (!o_raw_ready && n < 200);
    q.push_back(sat(v));
  endtask : put
  // a word latched by the host is checked at the next rising edge
  always @(posedge i_clk) begin
    logic [16:0] e;
    if (h_tick !== 1'b0) begin
      `CHK("word expected", 1'b1, q.size() != 0)
      e = (q.size() != 0) ? q.pop_front() : 17'h0_0000;
      `CHK("word", e[15:0], h_word)
      `CHK("flag", e[16], h_flag)
    end
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end
  initial begin
    repeat (10) @(negedge i_clk);
    i_sys_rst = 0;
    `CHK("reset word", WORD_RST, o_word)
    `CHK("reset strobe", 1'b1, o_new_word_strobe_n)
    `CHK("reset flag", 1'b0, o_range_exceeded_flag)
    put(20'h0_7FFF);
    put(20'h0_8000);
    put(20'hF_8000);
    put(20'hF_7FFF);
    put(20'h7_FFFF);
    put(20'h4_0000);
    put(20'h8_0000);
    put(20'h0_0001);
    put(20'hF_FFFF);
    for (int k = 0; k < 60; k++) begin
      r = $random(seed);
      put(r[20] ? r[19:0] : {{4{r[15]}}, r[15:0]});
      if (r[23:21] == 0) begin
        @(negedge i_clk) i_raw_valid = 0;
        repeat (30) @(negedge i_clk);
      end
    end
    @(negedge i_clk) i_raw_valid = 0;
    for (int k = 0; k < 2000 && q.size() > 0; k++) @(negedge i_clk);
    `CHK("pending", 0, q.size())
    results();
  end
endmodule : aof_top_test
